/* File: logic/ioddr_pkg.sv */
// constants, field layouts and carrier types of the double-rate pad-cell group
// assumes one core clock; every figure here is used by the group, its fifo takes only depth and width
//
// How it works
// - each cell: six registers, one latch, buffer
// - double-rate input uses both capture registers, latch
// - double-rate output uses both output registers
// - one enable register runs on falling edge
// - a group holds at most four cells
// - eight low-skew group clocks from clock networks
// - each cell picks its own control sources
// - row groups drive three routes, columns one
// - output and enable registers share clock, enable
// - first bit while clock high, second while low
// - latch holds high-time data, aligning both bits
package ioddr_pkg;

  // ----------------------------------------------------------------
  // group shape
  // ----------------------------------------------------------------
  localparam int CELL_COUNT   = 4;  // cells per row or column group
  localparam int IO_CLK_COUNT = 8;  // dedicated group clocks
  localparam int SEL_W        = 4;  // width of a clock source select
  localparam int FIFO_DEPTH   = 4;  // words buffered on the capture path

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_FABRIC_LANE = 4'h8; // select the fabric clock lane
  localparam logic             CLR_LEVEL       = 1'b0; // value left by a clear
  localparam logic             PRE_LEVEL       = 1'b1; // value left by a preset
  localparam logic             FLAG_RST        = 1'b0; // reset value of status flags

  // routing target of captured data
  typedef enum logic [1:0] {
    IODDR_ROUTE_ROW,
    IODDR_ROUTE_COL,
    IODDR_ROUTE_DIRECT
  } ioddr_route_t;

  // per-cell lines driven by the fabric, one lane each
  typedef struct packed {
    logic dout_a;  // first output bit
    logic dout_b;  // second output bit
    logic oe;      // drive enable
    logic ce_in;   // capture enable
    logic ce_out;  // output and enable register enable
    logic clk;     // fabric clock lane, used as a tick
    logic aclr;    // async clear or preset
    logic sclr;    // sync clear or preset
  } ioddr_lane_t;

  // per-cell configuration
  typedef struct packed {
    logic             ddr_in;     // double-rate capture
    logic             ddr_out;    // double-rate drive
    logic             oe_ddr;     // hold enable until falling edge
    logic [SEL_W-1:0] clk_in_sel; // 0..7 group clock, 8 fabric lane
    logic [SEL_W-1:0] clk_out_sel;
    logic             ce_in_use;  // honour lane capture enable
    logic             ce_out_use; // honour lane output enable
    logic             aclr_use;   // honour lane async line
    logic             sclr_use;   // honour lane sync line
    logic             preset;     // clears act as presets
  } ioddr_cell_cfg_t;

endpackage

/* File: logic/ioddr_fifo.sv */
// small synchronous fifo on the captured-data path
// assumes one clock; both sides use valid and ready
`timescale 1ns/1ps
module ioddr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  import ioddr_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [DEPTH];    // entries
  logic [AW-1:0]    wr_reg, wr_next;    // write pointer
  logic [AW-1:0]    rd_reg, rd_next;    // read pointer
  logic [AW:0]      cnt_reg, cnt_next;  // fill level
  logic             full_reg, full_next;
  logic             push, pop;

  assign push = in_valid_in & ~full_reg;     // refuse when full
  assign pop  = out_ready_in & (cnt_reg != '0);

  // pointer and level update, wrap at depth
  always_comb begin
    wr_next   = wr_reg;
    rd_next   = rd_reg;
    cnt_next  = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    full_next = (cnt_next == (AW+1)'(DEPTH));
  end

  // registers only; full is a flop so ready is clean
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      full_reg <= 1'b0;
    end else begin
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      cnt_reg  <= cnt_next;
      full_reg <= full_next;
    end
  end

  // data array has no reset, content is qualified by the level
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end

  assign in_ready_out  = ~full_reg;
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];

endmodule

/* File: logic/ioddr_group.sv */
// row or column group of up to four double-rate pad cells
// assumes fabric lanes and group clocks are synchronous ticks of core_clk_in;
// the falling-edge flops use the same clock, so there is no second domain
`timescale 1ns/1ps
module ioddr_group #(
  parameter int CELLS  = ioddr_pkg::CELL_COUNT,
  parameter bit IS_ROW = 1'b1,
  parameter int DEPTH  = ioddr_pkg::FIFO_DEPTH
) (
  input  wire logic                                  core_clk_in,
  input  wire logic                                  sys_rst_in,
  input  wire ioddr_pkg::ioddr_lane_t     [CELLS-1:0] lane_in,
  input  wire ioddr_pkg::ioddr_cell_cfg_t [CELLS-1:0] cfg_in,
  input  wire logic [ioddr_pkg::IO_CLK_COUNT-1:0]    io_clk_in,
  input  wire ioddr_pkg::ioddr_route_t               route_sel_in,
  input  wire logic                                  drop_clr_in,
  input  wire logic [CELLS-1:0]                      pad_in_in,
  output logic      [CELLS-1:0]                      pad_out_out,
  output logic      [CELLS-1:0]                      pad_oe_out,
  output logic      [2*CELLS-1:0]                    row_data_out,
  output logic      [2*CELLS-1:0]                    col_data_out,
  output logic      [2*CELLS-1:0]                    direct_data_out,
  output logic                                       cap_valid_out,
  input  wire logic                                  cap_ready_in,
  output logic      [2*CELLS-1:0]                    cap_data_out,
  output logic                                       drop_flag_out
);
  import ioddr_pkg::*;

  // ----------------------------------------------------------------
  // shared capture signals
  // ----------------------------------------------------------------
  logic [CELLS-1:0]   in_en;           // per-cell capture tick
  logic [CELLS-1:0]   tick_reg, tick_next; // capture ticks of the last rising edge
  logic [2*CELLS-1:0] pair_w;          // aligned pairs, second bit high
  logic [2*CELLS-1:0] cap_reg, cap_next;
  logic               cap_vld_reg, cap_vld_next;
  logic [2*CELLS-1:0] row_reg, row_next;
  logic [2*CELLS-1:0] col_reg, col_next;
  logic [2*CELLS-1:0] dir_reg, dir_next;
  logic               drop_reg, drop_next;
  logic               fifo_ready;

  // ----------------------------------------------------------------
  // per-cell logic
  // ----------------------------------------------------------------
  // group never exceeds four cells
  generate
    for (genvar g = 0; g < CELLS; g++) begin : g_cell
      ioddr_lane_t     lane;
      ioddr_cell_cfg_t cfg;
      logic in_tick, out_tick, out_en;
      logic aclr_hit, sclr_hit, clr_a, set_a, sval;
      // six storage flops and one latch
      logic in_pos_reg, in_pos_next;   // rising-edge capture
      logic in_neg_reg, in_neg_next;   // falling-edge capture
      logic out_a_reg,  out_a_next;    // first output bit
      logic out_b_reg,  out_b_next;    // second output bit
      logic oe_pos_reg, oe_pos_next;   // enable, rising edge
      logic oe_neg_reg, oe_neg_next;   // enable, falling edge
      logic in_lat;                    // high-time hold latch

      assign lane = lane_in[g];
      assign cfg  = cfg_in[g];

      // own clock source choice, group clock or fabric lane
      assign in_tick  = (cfg.clk_in_sel  < SEL_FABRIC_LANE) ? io_clk_in[cfg.clk_in_sel[2:0]]  : lane.clk;
      assign out_tick = (cfg.clk_out_sel < SEL_FABRIC_LANE) ? io_clk_in[cfg.clk_out_sel[2:0]] : lane.clk;
      assign in_en[g] = in_tick & (~cfg.ce_in_use | lane.ce_in);
      // data and enable registers share one tick and one enable
      assign out_en   = out_tick & (~cfg.ce_out_use | lane.ce_out);

      // clear or preset sources; sys reset always clears
      assign aclr_hit = cfg.aclr_use & lane.aclr;
      assign sclr_hit = cfg.sclr_use & lane.sclr;
      assign clr_a    = sys_rst_in | (aclr_hit & ~cfg.preset);
      assign set_a    = ~sys_rst_in & aclr_hit & cfg.preset;
      assign sval     = cfg.preset ? PRE_LEVEL : CLR_LEVEL;

      // next values; sync clear only acts on an enabled edge
      always_comb begin
        in_pos_next = in_pos_reg;
        in_neg_next = in_neg_reg;
        out_a_next  = out_a_reg;
        out_b_next  = out_b_reg;
        oe_pos_next = oe_pos_reg;
        // falling copy retimes the rising one every period, so the pin
        // enable rises at the first falling edge after its tick
        oe_neg_next = oe_pos_reg;
        if (in_en[g]) begin
          in_pos_next = sclr_hit ? sval : pad_in_in[g];
        end
        // second bit belongs to the tick of the rising edge just before
        if (tick_reg[g]) begin
          in_neg_next = sclr_hit ? sval : pad_in_in[g];
        end
        if (out_en) begin
          out_a_next  = sclr_hit ? sval : lane.dout_a;
          out_b_next  = sclr_hit ? sval : lane.dout_b;
          oe_pos_next = sclr_hit ? sval : lane.oe;
        end
      end

      // rising-edge registers, async clear or preset wins at once
      always_ff @(posedge core_clk_in or posedge clr_a or posedge set_a) begin
        if (clr_a) begin
          in_pos_reg <= CLR_LEVEL;
          out_a_reg  <= CLR_LEVEL;
          out_b_reg  <= CLR_LEVEL;
          oe_pos_reg <= CLR_LEVEL;
        end else if (set_a) begin
          in_pos_reg <= PRE_LEVEL;
          out_a_reg  <= PRE_LEVEL;
          out_b_reg  <= PRE_LEVEL;
          oe_pos_reg <= PRE_LEVEL;
        end else begin
          in_pos_reg <= in_pos_next;
          out_a_reg  <= out_a_next;
          out_b_reg  <= out_b_next;
          oe_pos_reg <= oe_pos_next;
        end
      end

      // falling-edge registers
      always_ff @(negedge core_clk_in or posedge clr_a or posedge set_a) begin
        if (clr_a) begin
          in_neg_reg <= CLR_LEVEL;
          oe_neg_reg <= CLR_LEVEL;
        end else if (set_a) begin
          in_neg_reg <= PRE_LEVEL;
          oe_neg_reg <= PRE_LEVEL;
        end else begin
          in_neg_reg <= in_neg_next;
          oe_neg_reg <= oe_neg_next;
        end
      end

      // transparent while clock low, holds through the high time,
      // so both bits are seen at the same rising edge
      always_latch begin
        if (!core_clk_in) begin
          in_lat = in_neg_reg;
        end
      end

      // single rate repeats the rising sample in both halves
      assign pair_w[2*g]   = in_pos_reg;
      assign pair_w[2*g+1] = cfg.ddr_in ? in_lat : in_pos_reg;

      // pin mux follows the clock; a glitch-free flop output is
      // impossible at twice the clock rate, so this one path is gated
      assign pad_out_out[g] = (cfg.ddr_out && !core_clk_in) ? out_b_reg : out_a_reg;
      // enable held inactive until the falling copy also asserts
      assign pad_oe_out[g]  = cfg.oe_ddr ? (oe_pos_reg & oe_neg_reg) : oe_pos_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // aligned capture, routing and drop flag
  // ----------------------------------------------------------------
  // capture word taken whenever any cell ticks; one shared word per edge
  always_comb begin
    cap_next     = cap_reg;
    // word built one edge after the tick, once the second bit sits in the latch
    cap_vld_next = |tick_reg;
    tick_next    = in_en;
    row_next     = row_reg;
    col_next     = col_reg;
    dir_next     = dir_reg;
    drop_next    = drop_reg;
    if (|tick_reg) begin
      cap_next = pair_w;
    end
    // column groups only reach column routing
    if (cap_vld_reg) begin
      unique case (route_sel_in)
        IODDR_ROUTE_ROW: begin
          if (IS_ROW) row_next = cap_reg;
        end
        IODDR_ROUTE_COL: begin
          col_next = cap_reg;
        end
        IODDR_ROUTE_DIRECT: begin
          if (IS_ROW) dir_next = cap_reg;
        end
        default: begin
          col_next = col_reg;
        end
      endcase
    end
    // a drop in the clearing cycle keeps the flag set
    if (drop_clr_in) begin
      drop_next = 1'b0;
    end
    if (cap_vld_reg && !fifo_ready) begin
      drop_next = 1'b1;
    end
  end

  // capture and status registers
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_reg     <= '0;
      cap_vld_reg <= 1'b0;
      tick_reg    <= '0;
      row_reg     <= '0;
      col_reg     <= '0;
      dir_reg     <= '0;
      drop_reg    <= FLAG_RST;
    end else begin
      cap_reg     <= cap_next;
      cap_vld_reg <= cap_vld_next;
      tick_reg    <= tick_next;
      row_reg     <= row_next;
      col_reg     <= col_next;
      dir_reg     <= dir_next;
      drop_reg    <= drop_next;
    end
  end

  assign row_data_out    = row_reg;
  assign col_data_out    = col_reg;
  assign direct_data_out = dir_reg;
  assign drop_flag_out   = drop_reg;

  // ----------------------------------------------------------------
  // capture buffer toward the fabric
  // ----------------------------------------------------------------
  // pad data cannot wait, so a full buffer drops and flags instead
  ioddr_fifo #(
    .WIDTH (2*CELLS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (cap_vld_reg),
    .in_ready_out  (fifo_ready),
    .in_data_in    (cap_reg),
    .out_valid_out (cap_valid_out),
    .out_ready_in  (cap_ready_in),
    .out_data_out  (cap_data_out)
  );

endmodule

/* File: tb/ioddr_group_asserts.sv */
// checker for the pad-cell group, fed only by the group's ports
// assumes cell 0 carries the plain configurations the bench applies
`timescale 1ns/1ps
module ioddr_group_asserts #(
  parameter int CELLS = 4
) (
  input  wire logic                                   core_clk_in,
  input  wire logic                                   sys_rst_in,
  input  wire ioddr_pkg::ioddr_lane_t     [CELLS-1:0] lane_in,
  input  wire ioddr_pkg::ioddr_cell_cfg_t [CELLS-1:0] cfg_in,
  input  wire logic [ioddr_pkg::IO_CLK_COUNT-1:0]     io_clk_in,
  input  wire ioddr_pkg::ioddr_route_t                route_sel_in,
  input  wire logic                                   drop_clr_in,
  input  wire logic [CELLS-1:0]                       pad_in_in,
  input  wire logic [CELLS-1:0]                       pad_out_out,
  input  wire logic [CELLS-1:0]                       pad_oe_out,
  input  wire logic [2*CELLS-1:0]                     row_data_out,
  input  wire logic                                   cap_valid_out,
  input  wire logic                                   cap_ready_in,
  input  wire logic [2*CELLS-1:0]                     cap_data_out,
  input  wire logic                                   drop_flag_out
);
  import ioddr_pkg::*;
  // ----------------------------------------------------------------
  // shadow of cell 0
  // ----------------------------------------------------------------
  logic       simple;   // group clock 0, no enable, no clear lines
  logic       trk_reg;  // shadow valid since a plain tick
  logic [2:0] out_reg;  // shadow of first bit, second bit, enable
  logic       ep_reg;   // enable shadow before the last rising edge
  logic       pp_reg;   // pad at the last rising edge
  logic       pn_reg;   // pad at the last falling edge
  logic [3:0] pr_reg;   // two stages of captured pairs
  logic       cap_ok;   // cell 0 captures double rate onto the row route
  assign simple = cfg_in[0].clk_out_sel == 4'h0 && !cfg_in[0].ce_out_use
                  && !cfg_in[0].aclr_use && !cfg_in[0].sclr_use;
  assign cap_ok = io_clk_in[1] && cfg_in[0].clk_in_sel == 4'h1 && cfg_in[0].ddr_in && !cfg_in[0].ce_in_use
                  && !cfg_in[0].aclr_use && !cfg_in[0].sclr_use && route_sel_in == IODDR_ROUTE_ROW;
  // shadow follows only plain ticks, so a missed enable cannot mislead it
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trk_reg <= 1'b0;
      out_reg <= 3'h0;
      ep_reg  <= 1'b0;
      pp_reg  <= 1'b0;
      pr_reg  <= 4'h0;
    end else begin
      trk_reg <= simple && (trk_reg || io_clk_in[0]);
      out_reg <= (simple && io_clk_in[0]) ? {lane_in[0].dout_a, lane_in[0].dout_b, lane_in[0].oe} : out_reg;
      ep_reg  <= out_reg[0];
      pp_reg  <= pad_in_in[0];
      pr_reg  <= {pr_reg[1:0], pn_reg, pp_reg};
    end
  end
  // falling-edge sample of the pad, as the latch sees it
  always_ff @(negedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pn_reg <= 1'b0;
    end else begin
      pn_reg <= pad_in_in[0];
    end
  end
  default clocking dcb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_OUT_LOW : assert property (trk_reg && simple |->
    pad_out_out[0] == (cfg_in[0].ddr_out ? out_reg[1] : out_reg[2])) else $error("pad data wrong in low phase");
  AST_OUT_HIGH : assert property (@(negedge core_clk_in) disable iff (sys_rst_in)
    trk_reg && simple |-> pad_out_out[0] == out_reg[2]) else $error("pad data wrong in high phase");
  AST_OE_SDR : assert property (trk_reg && simple && !cfg_in[0].oe_ddr |->
    pad_oe_out[0] == out_reg[0]) else $error("drive enable does not follow its register");
  AST_OE_LATE : assert property (@(negedge core_clk_in) disable iff (sys_rst_in)
    $past(trk_reg) && trk_reg && simple && cfg_in[0].oe_ddr && out_reg[0] && !ep_reg |-> !pad_oe_out[0])
    else $error("drive enable rose before the falling edge");
  AST_CAP_PAIR : assert property (cap_ok |-> ##3 row_data_out[1:0] == pr_reg[3:2])
    else $error("captured pair wrong on the row route");
  AST_CAP_HOLD : assert property (cap_valid_out && !cap_ready_in |=>
    cap_valid_out && $stable(cap_data_out)) else $error("stalled capture word changed");
  AST_DROP_KEEP : assert property (drop_flag_out && !drop_clr_in |=> drop_flag_out)
    else $error("drop flag lost without clear");
  AST_ACLR : assert property (cfg_in[0].aclr_use && lane_in[0].aclr |->
    pad_out_out[0] == cfg_in[0].preset) else $error("async clear not immediate");
  AST_SCLR : assert property (cfg_in[0].sclr_use && !cfg_in[0].aclr_use && lane_in[0].sclr && simple == 1'b0
    && cfg_in[0].clk_out_sel == 4'h0 && io_clk_in[0] && !cfg_in[0].ce_out_use && !cfg_in[0].ddr_out
    |=> pad_out_out[0] == $past(cfg_in[0].preset)) else $error("sync clear not applied at edge");
  // main scenarios reached
  COV_DDR  : cover property (trk_reg && cfg_in[0].ddr_out);
  COV_DROP : cover property (drop_flag_out);
  COV_POP  : cover property (cap_valid_out && cap_ready_in);
endmodule

bind ioddr_group ioddr_group_asserts #(.CELLS(CELLS)) chk_u (.core_clk_in, .sys_rst_in, .lane_in, .cfg_in,
  .io_clk_in, .route_sel_in, .drop_clr_in, .pad_in_in, .pad_out_out, .pad_oe_out, .row_data_out,
  .cap_valid_out, .cap_ready_in, .cap_data_out, .drop_flag_out);

/* File: tb/ioddr_pin_model.sv */
// far side of the pins: a double-rate source on each pad
// assumes the group's drive wins wherever its enable is high
`timescale 1ns/1ps
module ioddr_pin_model #(
  parameter int CELLS = 4
) (
  input  wire logic             core_clk_in,
  input  wire logic [CELLS-1:0] first_in,    // on the wire around the rising edge
  input  wire logic [CELLS-1:0] second_in,   // on the wire around the falling edge
  input  wire logic [CELLS-1:0] pad_out_in,
  input  wire logic [CELLS-1:0] pad_oe_in,
  output logic      [CELLS-1:0] pad_in_out
);
  logic [CELLS-1:0] far_bits;          // level the far device puts on the wire
  logic             phase_reg = 1'b0;  // clock seen a quarter period late
  // the wire switches a quarter period after each edge, so neither
  // sampling edge races the switch: first at rising, second at falling
  always @(core_clk_in) phase_reg <= #6 core_clk_in;
  assign far_bits   = phase_reg ? second_in : first_in;
  // wire level from both parties' drive
  assign pad_in_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & far_bits);
endmodule

/* File: tb/ioddr_group_tb.sv */
// self-checking bench for the pad-cell group
// assumes pin model on the pads; fabric lanes driven here
`timescale 1ns/1ps
module ioddr_group_tb;
  import ioddr_pkg::*;
  logic                  core_clk_in = 1'b0;
  logic                  sys_rst_in  = 1'b1;
  ioddr_lane_t     [3:0] lane        = '0;
  ioddr_cell_cfg_t [3:0] cfg         = '0;
  logic [7:0]            io_clk      = 8'h00;
  ioddr_route_t          route       = IODDR_ROUTE_ROW;
  logic                  drop_clr    = 1'b0;
  logic                  cap_ready   = 1'b1;
  logic [3:0]            first       = 4'h0;
  logic [3:0]            second      = 4'h0;
  logic                  oe_prev     = 1'b0;
  logic [3:0]            pad_in, pad_out, pad_oe;
  logic [7:0]            row_d, col_d, dir_d, cap_d;
  logic                  cap_valid, drop_flag;
  logic [7:0]            words[$];
  int                    failures = 0;
  int                    n_checks = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  ioddr_group dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .lane_in(lane), .cfg_in(cfg),
    .io_clk_in(io_clk), .route_sel_in(route), .drop_clr_in(drop_clr), .pad_in_in(pad_in), .pad_out_out(pad_out),
    .pad_oe_out(pad_oe), .row_data_out(row_d), .col_data_out(col_d), .direct_data_out(dir_d),
    .cap_valid_out(cap_valid), .cap_ready_in(cap_ready), .cap_data_out(cap_d), .drop_flag_out(drop_flag));
  ioddr_pin_model pin_u (.core_clk_in(core_clk_in), .first_in(first), .second_in(second), .pad_out_in(pad_out),
    .pad_oe_in(pad_oe), .pad_in_out(pad_in));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // expected capture word: even bit first, odd bit second
  function automatic logic [7:0] pair(input logic [3:0] f, input logic [3:0] s, input logic ddr);
    for (int g = 0; g < 4; g++) begin
      pair[2*g]   = f[g];
      pair[2*g+1] = ddr ? s[g] : f[g];
    end
  endfunction
  // m = {ddr_in, ddr_out, oe_ddr, aclr_use, sclr_use, preset}; cell 2 clocks in on its lane, cell 3 gated
  task automatic setup(input logic [5:0] m);
    @(posedge core_clk_in);
    for (int g = 0; g < 4; g++) begin
      cfg[g] <= '{m[5], m[4], m[3], (g == 2) ? SEL_FABRIC_LANE : 4'h1, 4'h0, g == 3, g == 3, m[2], m[1], m[0]};
    end
  endtask
  // one output tick, then both clock phases checked; cell 3 never enabled
  task automatic drive_out(input logic a, input logic b, input logic oe, input logic ddr);
    @(posedge core_clk_in);
    io_clk[0] <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      lane[g].dout_a <= a;
      lane[g].dout_b <= b;
      lane[g].oe     <= oe;
    end
    @(posedge core_clk_in);
    io_clk[0] <= 1'b0;
    #5;
    chk({4'h0, pad_out}, {5'h00, {3{a}}});
    chk({4'h0, pad_oe}, {5'h00, {3{ddr ? oe & oe_prev : oe}}});
    @(negedge core_clk_in);
    #5;
    chk({4'h0, pad_out}, {5'h00, {3{ddr ? b : a}}});
    chk({4'h0, pad_oe}, {5'h00, {3{oe}}});
    oe_prev = oe;
  endtask
  // one capture tick on group clock 1 and the fabric lane clock
  task automatic cap(input logic [3:0] f, input logic [3:0] s);
    @(posedge core_clk_in);
    io_clk[1] <= 1'b1;
    lane[2].clk <= 1'b1;
    first <= f;
    second <= s;
    @(posedge core_clk_in);
    io_clk[1] <= 1'b0;
    lane[2].clk <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    lane[3].ce_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    setup(6'h00);
    for (int i = 0; i < 4; i++) drive_out(i[0], i[1], i[0], 1'b0);
    setup(6'h38);
    for (int i = 0; i < 4; i++) drive_out(i[0], i[1], i[1], 1'b1);
    drive_out(1'b0, 1'b0, 1'b0, 1'b1);
    for (int r = 0; r < 3; r++) begin
      @(posedge core_clk_in);
      route <= ioddr_route_t'(r);
      cap(4'h5 + r[3:0], 4'ha - r[3:0]);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk(r == 0 ? row_d : r == 1 ? col_d : dir_d, pair(4'h5 + r[3:0], 4'ha - r[3:0], 1'b1));
    end
    // fill the fifo with the far side stalled; two words must be dropped
    @(posedge core_clk_in);
    route <= IODDR_ROUTE_ROW;
    cap_ready <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      cap(4'h3 * k[3:0], ~k[3:0]);
      if (k < 4) words.push_back(pair(4'h3 * k[3:0], ~k[3:0], 1'b1));
    end
    repeat (3) @(posedge core_clk_in);
    #1;
    chk({7'h00, drop_flag}, 8'h01);
    @(posedge core_clk_in);
    drop_clr <= 1'b1;
    @(posedge core_clk_in);
    drop_clr <= 1'b0;
    #1;
    chk({7'h00, drop_flag}, 8'h00);
    @(posedge core_clk_in);
    cap_ready <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      #1;
      chk({7'h00, cap_valid}, 8'h01);
      chk(cap_d, words[k]);
      @(posedge core_clk_in);
    end
    #1;
    chk({7'h00, cap_valid}, 8'h00);
    setup(6'h00);
    cap(4'h9, 4'h6);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(row_d, pair(4'h9, 4'h6, 1'b0));
    // async clear, async preset, then sync clear on an output tick
    drive_out(1'b1, 1'b1, 1'b1, 1'b0);
    for (int p = 0; p < 2; p++) begin
      setup({5'h02, p[0]});
      @(posedge core_clk_in);
      for (int g = 0; g < 4; g++) lane[g].aclr <= 1'b1;
      #1;
      chk({4'h0, pad_out}, {4'h0, {4{p[0]}}});
      @(posedge core_clk_in);
      for (int g = 0; g < 4; g++) lane[g].aclr <= 1'b0;
    end
    setup(6'h02);
    @(posedge core_clk_in);
    io_clk[0] <= 1'b1;
    for (int g = 0; g < 4; g++) lane[g].sclr <= 1'b1;
    #1;
    chk({5'h00, pad_out[2:0]}, 8'h07);
    @(posedge core_clk_in);
    io_clk[0] <= 1'b0;
    for (int g = 0; g < 4; g++) lane[g].sclr <= 1'b0;
    #1;
    chk({4'h0, pad_out}, 8'h08);
    give_verdict();
  end
  // hang guard, far beyond the fewer than a hundred cycles the sequence needs
  initial begin
    #(25 * 3000);
    failures++;
    give_verdict();
  end
endmodule
